// File: sysctl_pkg.sv
// constants for the reset sequencer and peripheral power gating block
// assumes a 50 MHz system clock and a 32-bit register bus with byte addresses
`default_nettype none

package sysctl_pkg;

    // system clock
    localparam int          CLK_MHZ          = 50;

    // register byte addresses
    localparam logic [7:0]  ADDR_GATE        = 8'h64;
    localparam logic [7:0]  ADDR_STATUS      = 8'h68;

    // peripheral_power_gate layout
    localparam logic [7:0]  GATE_RESET       = 8'h00;
    localparam logic [7:0]  GATE_WRITE_MASK  = 8'hEF;
    localparam int          BIT_TWO_WIRE     = 7;
    localparam int          BIT_TIMER2       = 6;
    localparam int          BIT_TIMER0       = 5;
    localparam int          BIT_RESERVED     = 4;
    localparam int          BIT_TIMER1       = 3;
    localparam int          BIT_SERIAL       = 2;
    localparam int          BIT_UART0        = 1;
    localparam int          BIT_CONVERTER    = 0;

    // status register layout
    localparam int          STAT_BANDGAP     = 0;
    localparam int          STAT_BROWNOUT    = 1;
    localparam int          STAT_T2_STOPPED  = 2;
    localparam int          STAT_ADC_FAULT   = 3;

    // bus responses
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

    // fuse encodings: all ones means unprogrammed
    localparam logic [2:0]  BOD_FUSE_OFF     = 3'h7;

    // delay counter: base time-out, doubled per step of the fuse index
    localparam int          TOUT_BASE_US     = 64;
    localparam int          TOUT_BASE_CYCLES = TOUT_BASE_US * CLK_MHZ;
    localparam int          COUNT_W          = 20;

    // sequencer states
    typedef enum logic [1:0] {
        SEQ_HOLD,
        SEQ_COUNT,
        SEQ_RUN
    } seq_state_t;

endpackage

`default_nettype wire

// File: sync_two_ff.sv
// two flip-flop synchroniser, also usable as a reset release synchroniser
// assumes d is static or slow compared with clk
`default_nettype none

module sync_two_ff #(
    parameter int         WIDTH     = 1,
    parameter logic       RESET_VAL = 1'b0
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    // data
    input  wire logic [WIDTH-1:0]  d,
    output logic      [WIDTH-1:0]  q
);

    logic [WIDTH-1:0] meta_r;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= {WIDTH{RESET_VAL}};
            q      <= {WIDTH{RESET_VAL}};
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule

`default_nettype wire

// File: reset_stretch.sv
// delay counter that stretches the internal reset after all sources go quiet
// assumes hold_n is the raw asynchronous combination of reset sources
`default_nettype none

module reset_stretch #(
    parameter int COUNT_W = 20
) (
    // clock and asynchronous hold
    input  wire logic               clk,
    input  wire logic               hold_n,
    // synchronous restart pulse and selected delay
    input  wire logic               restart,
    input  wire logic [COUNT_W-1:0] delay_cycles,
    // results
    output logic                    sys_reset_active,
    output logic                    run_start
);

    logic                         released;
    sysctl_pkg::seq_state_t       state_r;
    sysctl_pkg::seq_state_t       state_nxt;
    logic [COUNT_W-1:0]           count_r;
    logic [COUNT_W-1:0]           count_nxt;
    logic                         start_nxt;

    // release is synchronised, assertion stays asynchronous
    sync_two_ff #(.WIDTH(1), .RESET_VAL(1'b0)) u_release (
        .clk    (clk),
        .arst_n (hold_n),
        .d      (1'b1),
        .q      (released)
    );

    // sequencer next state
    always_comb begin
        state_nxt = state_r;
        count_nxt = count_r;
        start_nxt = 1'b0;
        case (state_r)
            sysctl_pkg::SEQ_HOLD: begin
                if (released) begin
                    state_nxt = sysctl_pkg::SEQ_COUNT;
                    count_nxt = '0;
                end
            end
            sysctl_pkg::SEQ_COUNT: begin
                if (restart) begin
                    count_nxt = '0;
                end else if (count_r >= delay_cycles - COUNT_W'(1)) begin
                    state_nxt = sysctl_pkg::SEQ_RUN;
                    start_nxt = 1'b1;
                end else begin
                    count_nxt = count_r + COUNT_W'(1);
                end
            end
            sysctl_pkg::SEQ_RUN: begin
                // watchdog pulse: counting begins once it has fallen
                if (restart) begin
                    state_nxt = sysctl_pkg::SEQ_COUNT;
                    count_nxt = '0;
                end
            end
            default: begin
                state_nxt = sysctl_pkg::SEQ_HOLD;
                count_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge hold_n) begin
        if (!hold_n) begin
            state_r   <= sysctl_pkg::SEQ_HOLD;
            count_r   <= '0;
            run_start <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            count_r   <= count_nxt;
            run_start <= start_nxt;
        end
    end

    // reset stands at once on the pulse, lifts only from the run state
    assign sys_reset_active = (state_r != sysctl_pkg::SEQ_RUN) || restart;

endmodule

`default_nettype wire

// File: sysctl_top.sv
// reset combination, delay stretching, bandgap control and clock gating
// assumes an AXI4-Lite master on clk, analog detectors as raw levels
// How it works
// - two-wire gate bit stops its clock
// - timer2 gate acts only when synchronous
// - timer0 and timer1 gates freeze, resume
// - reserved bit four always reads zero
// - serial and uart gates stop clocks
// - converter gate blocks comparator mux path
// - reset restores registers, starts at vector
// - ports reset at once without clock; the watchdog pulse leaves io_port_reset low
// - fuse-selected delay stretches internal reset
// - four reset sources combined into one
// - watchdog resets only in reset mode
// - watchdog gives one-cycle pulse, then delay
// - power-on drop resets at once
// - long pin low resets without clock
// - pin rise released through delay counter
// - pin disable fuse ignores external pin
// - brown-out resets at once, delayed release
// - level fuses select, enable brown-out
// - bandgap on only when something needs it
//
// Our own choice: the AXI4-Lite interface to the registers.
`default_nettype none

module sysctl_top #(
    parameter int TOUT_BASE_CYCLES = sysctl_pkg::TOUT_BASE_CYCLES
) (
    // clock and power-on style reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // AXI4-Lite write channels
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read channels
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // raw reset sources
    input  wire logic        por_active,
    input  wire logic        reset_pin_n,
    input  wire logic        bod_below,
    input  wire logic        wdt_expire,
    input  wire logic        wdt_reset_mode_en,
    // fuses
    input  wire logic [1:0]  startup_time_fuse,
    input  wire logic [3:0]  clock_select_fuse,
    input  wire logic        reset_pin_disable_fuse,
    input  wire logic [2:0]  brownout_level_fuse,
    // peripheral state
    input  wire logic        timer2_async_select,
    input  wire logic        comparator_bandgap_select,
    input  wire logic        adc_enable,
    // reset results
    output logic             io_port_reset,
    output logic             sys_reset_active,
    output logic             run_start,
    // analog control
    output logic             bandgap_on,
    output logic             brownout_enable,
    output logic [2:0]       brownout_trigger_level,
    // peripheral clock enables
    output logic             two_wire_clk_en,
    output logic             timer2_clk_en,
    output logic             timer0_clk_en,
    output logic             timer1_clk_en,
    output logic             spi_clk_en,
    output logic             uart0_clk_en,
    output logic             adc_clk_en,
    output logic             comparator_mux_allow
);

    localparam int CW = sysctl_pkg::COUNT_W;

    logic             ext_active;
    logic             bod_active;
    logic             hold_n;
    logic [2:0]       fuse_sync;
    logic [2:0]       delay_idx;
    logic [CW-1:0]    delay_sel;
    logic             wdt_pulse_r;
    logic             wdt_pulse_nxt;
    logic             aw_held_r;
    logic             aw_held_nxt;
    logic [7:0]       awaddr_r;
    logic [7:0]       awaddr_nxt;
    logic             w_held_r;
    logic             w_held_nxt;
    logic [7:0]       wbyte_r;
    logic [7:0]       wbyte_nxt;
    logic             wlane_r;
    logic             wlane_nxt;
    logic             bvalid_r;
    logic             bvalid_nxt;
    logic [1:0]       bresp_r;
    logic [1:0]       bresp_nxt;
    logic             rvalid_r;
    logic             rvalid_nxt;
    logic [31:0]      rdata_r;
    logic [31:0]      rdata_nxt;
    logic [1:0]       rresp_r;
    logic [1:0]       rresp_nxt;
    logic [7:0]       gate_r;
    logic [7:0]       gate_nxt;
    logic             adc_fault_r;
    logic             adc_fault_nxt;
    logic             do_write;
    logic             fault_clear;
    logic [7:0]       status_view;

    assign ext_active = !reset_pin_n && !reset_pin_disable_fuse;

    assign brownout_enable        = (brownout_level_fuse != sysctl_pkg::BOD_FUSE_OFF);
    assign brownout_trigger_level = brownout_level_fuse;
    assign bod_active = bod_below && brownout_enable;

    // clockless pin reset
    // asynchronous path on purpose: must act with no clock running
    assign hold_n = resetn && !por_active && !ext_active && !bod_active;

    assign io_port_reset = !hold_n;

    // fuses are static but come from another domain
    sync_two_ff #(.WIDTH(3), .RESET_VAL(1'b0)) u_fuse_sync (
        .clk    (clk),
        .arst_n (resetn),
        .d      ({clock_select_fuse[0], startup_time_fuse}),
        .q      (fuse_sync)
    );

    // fuse-selected delay
    // each index step doubles the base time-out
    assign delay_idx = {fuse_sync[2], fuse_sync[1:0]};
    assign delay_sel = CW'(TOUT_BASE_CYCLES) << delay_idx;

    always_comb begin
        wdt_pulse_nxt = wdt_expire && wdt_reset_mode_en && !wdt_pulse_r;
    end

    always_ff @(posedge clk or negedge hold_n) begin
        if (!hold_n) begin
            wdt_pulse_r <= 1'b0;
        end else begin
            wdt_pulse_r <= wdt_pulse_nxt;
        end
    end

    reset_stretch #(.COUNT_W(CW)) u_stretch (
        .clk              (clk),
        .hold_n           (hold_n),
        .restart          (wdt_pulse_r),
        .delay_cycles     (delay_sel),
        .sys_reset_active (sys_reset_active),
        .run_start        (run_start)
    );

    // bus handshakes: one write and one read outstanding
    assign awready  = !aw_held_r && !bvalid_r;
    assign wready   = !w_held_r && !bvalid_r;
    assign arready  = !rvalid_r;
    assign do_write = aw_held_r && w_held_r;
    assign bvalid   = bvalid_r;
    assign bresp    = bresp_r;
    assign rvalid   = rvalid_r;
    assign rdata    = rdata_r;
    assign rresp    = rresp_r;

    assign bandgap_on = brownout_enable || comparator_bandgap_select || adc_enable;

    assign status_view = {4'h0, adc_fault_r, !timer2_clk_en, brownout_enable, bandgap_on};

    // bus, gate and fault next values
    always_comb begin
        aw_held_nxt   = aw_held_r;
        awaddr_nxt    = awaddr_r;
        w_held_nxt    = w_held_r;
        wbyte_nxt     = wbyte_r;
        wlane_nxt     = wlane_r;
        bvalid_nxt    = bvalid_r;
        bresp_nxt     = bresp_r;
        rvalid_nxt    = rvalid_r;
        rdata_nxt     = rdata_r;
        rresp_nxt     = rresp_r;
        gate_nxt      = gate_r;
        fault_clear   = 1'b0;
        if (awvalid && awready) begin
            aw_held_nxt = 1'b1;
            awaddr_nxt  = awaddr;
        end
        if (wvalid && wready) begin
            w_held_nxt = 1'b1;
            wbyte_nxt  = wdata[7:0];
            wlane_nxt  = wstrb[0];
        end
        if (bvalid_r && bready) begin
            bvalid_nxt = 1'b0;
        end
        if (do_write) begin
            aw_held_nxt = 1'b0;
            w_held_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = sysctl_pkg::RESP_OKAY;
            if (awaddr_r == sysctl_pkg::ADDR_GATE) begin
                if (wlane_r) begin
                    gate_nxt = wbyte_r & sysctl_pkg::GATE_WRITE_MASK;
                end
            end else if (awaddr_r == sysctl_pkg::ADDR_STATUS) begin
                fault_clear = wlane_r && wbyte_r[sysctl_pkg::STAT_ADC_FAULT];
            end else begin
                bresp_nxt = sysctl_pkg::RESP_SLVERR;
            end
        end
        if (rvalid_r && rready) begin
            rvalid_nxt = 1'b0;
        end
        if (arvalid && arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = sysctl_pkg::RESP_OKAY;
            if (araddr == sysctl_pkg::ADDR_GATE) begin
                rdata_nxt = {24'h000000, gate_r & sysctl_pkg::GATE_WRITE_MASK};
            end else if (araddr == sysctl_pkg::ADDR_STATUS) begin
                rdata_nxt = {24'h000000, status_view};
            end else begin
                rdata_nxt = 32'h00000000;
                rresp_nxt = sysctl_pkg::RESP_SLVERR;
            end
        end
        if (sys_reset_active) begin
            gate_nxt = sysctl_pkg::GATE_RESET;
        end
        // gating an active converter
        // set wins over a same-cycle clear
        adc_fault_nxt = (adc_fault_r && !fault_clear) ||
                        (adc_enable && gate_r[sysctl_pkg::BIT_CONVERTER]);
        if (sys_reset_active) begin
            adc_fault_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aw_held_r   <= 1'b0;
            awaddr_r    <= 8'h00;
            w_held_r    <= 1'b0;
            wbyte_r     <= 8'h00;
            wlane_r     <= 1'b0;
            bvalid_r    <= 1'b0;
            bresp_r     <= sysctl_pkg::RESP_OKAY;
            rvalid_r    <= 1'b0;
            rdata_r     <= 32'h00000000;
            rresp_r     <= sysctl_pkg::RESP_OKAY;
            gate_r      <= sysctl_pkg::GATE_RESET;
            adc_fault_r <= 1'b0;
        end else begin
            aw_held_r   <= aw_held_nxt;
            awaddr_r    <= awaddr_nxt;
            w_held_r    <= w_held_nxt;
            wbyte_r     <= wbyte_nxt;
            wlane_r     <= wlane_nxt;
            bvalid_r    <= bvalid_nxt;
            bresp_r     <= bresp_nxt;
            rvalid_r    <= rvalid_nxt;
            rdata_r     <= rdata_nxt;
            rresp_r     <= rresp_nxt;
            gate_r      <= gate_nxt;
            adc_fault_r <= adc_fault_nxt;
        end
    end

    assign two_wire_clk_en = !gate_r[sysctl_pkg::BIT_TWO_WIRE];
    // synchronous timer2 only
    // an asynchronous timer2 keeps its own clock, so the gate has no hold
    assign timer2_clk_en = !(gate_r[sysctl_pkg::BIT_TIMER2] && !timer2_async_select);
    // freeze and resume
    // enables only stall the timers, their state is kept intact
    assign timer0_clk_en = !gate_r[sysctl_pkg::BIT_TIMER0];
    assign timer1_clk_en = !gate_r[sysctl_pkg::BIT_TIMER1];
    // debug use of the serial gate is left to software
    assign spi_clk_en    = !gate_r[sysctl_pkg::BIT_SERIAL];
    assign uart0_clk_en  = !gate_r[sysctl_pkg::BIT_UART0];
    assign adc_clk_en           = !gate_r[sysctl_pkg::BIT_CONVERTER];
    assign comparator_mux_allow = !gate_r[sysctl_pkg::BIT_CONVERTER];

    // checks on the design's own outputs
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence gate_write_s(int b);
        do_write && awaddr_r == sysctl_pkg::ADDR_GATE && wlane_r && wbyte_r[b]
            && !sys_reset_active;
    endsequence

    two_wire_stop_a: assert property (gate_write_s(7) |=> !two_wire_clk_en)
        else $error("two-wire clock not stopped after gate write");
    timer2_sync_a: assert property (
        gate_r[6] && timer2_async_select |-> timer2_clk_en)
        else $error("timer2 gated while asynchronous");
    timer_resume_a: assert property (
        $fell(gate_r[5]) |-> timer0_clk_en && $past(!timer0_clk_en))
        else $error("timer0 did not resume on ungate");
    reserved_read_a: assert property (
        arvalid && arready |=> rdata_r[4] == 1'b0)
        else $error("reserved bit read as one");
    serial_stop_a: assert property (
        gate_write_s(2) |=> !spi_clk_en && adc_clk_en == !gate_r[0])
        else $error("serial clock not stopped after gate write");
    converter_mux_a: assert property (
        !adc_clk_en |-> !comparator_mux_allow)
        else $error("comparator mux open while converter gated");
    wdt_pulse_a: assert property (
        wdt_pulse_r |=> !wdt_pulse_r && sys_reset_active)
        else $error("watchdog pulse not one cycle or reset released");
    wdt_mode_a: assert property (
        !wdt_reset_mode_en |=> !wdt_pulse_r)
        else $error("watchdog reset outside reset mode");
    gate_clear_a: assert property (
        sys_reset_active |=> gate_r == sysctl_pkg::GATE_RESET)
        else $error("gate bits not cleared during reset");
    bandgap_need_a: assert property (
        bandgap_on == (brownout_enable || comparator_bandgap_select || adc_enable))
        else $error("bandgap state does not match demand");
    stretch_hold_a: assert property (
        $rose(run_start) |-> $past(sys_reset_active, 2))
        else $error("run started without stretched reset");
    bod_fuse_a: assert property (
        brownout_level_fuse == sysctl_pkg::BOD_FUSE_OFF |-> !brownout_enable)
        else $error("brown-out enabled with unprogrammed fuses");

endmodule

`default_nettype wire

// File: periph_model.sv
// far-side model: reset sources, peripheral levels and one gated timer
// assumes the bench calls its tasks just after a rising edge of clk
`default_nettype none

module periph_model (
    // clock and gated timer enable
    input  wire logic        clk,
    input  wire logic        timer0_clk_en,
    // reset sources
    output var logic         por_active,
    output var logic         reset_pin_n,
    output var logic         bod_below,
    output var logic         wdt_expire,
    // peripheral state
    output var logic         timer2_async_select,
    output var logic         comparator_bandgap_select,
    output var logic         adc_enable,
    output var logic [15:0]  timer0_count
);
    timeunit 1ns;
    timeprecision 1ps;

    // quiet sources and idle peripherals at power-up
    initial begin
        {por_active, bod_below, wdt_expire, timer0_count} = '0;
        reset_pin_n = 1'b1;
        {timer2_async_select, comparator_bandgap_select, adc_enable} = '0;
    end

    // timer holds state
    // counts only while its clock runs, so a gated stretch leaves it frozen
    always @(posedge clk) begin
        if (timer0_clk_en === 1'b1) begin
            timer0_count <= timer0_count + 16'h0001;
        end
    end

    // four reset sources
    // pin is active low, the others active high
    task automatic set_src(input int k, input logic on);
        case (k)
            0: reset_pin_n <= !on;
            1: por_active <= on;
            2: bod_below <= on;
            default: wdt_expire <= on;
        endcase
    endtask

    // no debug link modelled
    // software level inputs, changed only by the bench's sequence
    task automatic set_periph(input logic asy, input logic cbs, input logic adc);
        timer2_async_select <= asy;
        comparator_bandgap_select <= cbs;
        adc_enable <= adc;
    endtask
endmodule

`default_nettype wire

// File: reset_and_peripheral_power_gating_tb_top.sv
// self-checking bench for the reset sequencer and clock gating block
// assumes the far-side model in periph_model and a short delay base
`default_nettype none

`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_fail++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end

module reset_and_peripheral_power_gating_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 0, resetn = 0;
    logic [7:0]  awaddr = '0, araddr = '0;
    // response readies held high, so each answer is taken at the edge it shows
    logic        awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1;
    logic [31:0] wdata = '0, rdata;
    logic [3:0]  wstrb = 4'hF;
    logic [1:0]  bresp, rresp, startup_time_fuse = '0;
    logic        awready, wready, bvalid, arready, rvalid, wdt_reset_mode_en = 0;
    logic [3:0]  clock_select_fuse = '0;
    logic        reset_pin_disable_fuse = 0;
    logic [2:0]  brownout_level_fuse = 3'h7, brownout_trigger_level;
    logic        por_active, reset_pin_n, bod_below, wdt_expire;
    logic        timer2_async_select, comparator_bandgap_select, adc_enable;
    logic        io_port_reset, sys_reset_active, run_start, bandgap_on, brownout_enable;
    logic        two_wire_clk_en, timer2_clk_en, timer0_clk_en, timer1_clk_en;
    logic        spi_clk_en, uart0_clk_en, adc_clk_en, comparator_mux_allow;
    logic [15:0] timer0_count, t0;
    logic [7:0]  en, rd;
    logic [1:0]  rsp;
    int          n_fail = 0, samples_checked = 0, cyc = 0, n;

    // short delay base keeps every stretched reset within a few dozen cycles
    sysctl_top #(.TOUT_BASE_CYCLES(8)) i_dut (.*);
    periph_model i_part (.*);

    // gate enables in register bit order, reserved slot shown as running
    assign en = {two_wire_clk_en, timer2_clk_en, timer0_clk_en, 1'b1,
                 timer1_clk_en, spi_clk_en, uart0_clk_en, adc_clk_en};

    // 50 MHz clock
    initial begin
        forever #10 clk = ~clk;
    end

    // hang guard, far above the longest expected run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // one write: address and data offered together, each released when taken
    task automatic axw(input logic [7:0] a, input logic [7:0] d);
        awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1; wvalid <= 1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
        end while (bvalid !== 1'b1);
        rsp = bresp;
    endtask

    task automatic axr(input logic [7:0] a);
        araddr <= a; arvalid <= 1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 0;
        end while (rvalid !== 1'b1);
        rd = rdata[7:0]; rsp = rresp;
    endtask

    // counts edges until the release pulse, bounded
    task automatic wait_run();
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (run_start !== 1'b1 && n < 400);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1;
        wait_run();
        axr(sysctl_pkg::ADDR_GATE);
        `CHK("gate after reset", 8'h00, rd)
        axr(8'h70);
        `CHK("unmapped read", sysctl_pkg::RESP_SLVERR, rsp)
        // each gate bit alone, timer2 synchronous, adc disabled first
        for (int i = 0; i < 8; i++) begin
            axw(sysctl_pkg::ADDR_GATE, 8'h01 << i);
            axr(sysctl_pkg::ADDR_GATE);
            `CHK("gate readback", (8'h01 << i) & 8'hEF, rd)
            `CHK("clock enables", ~((8'h01 << i) & 8'hEF), en)
            `CHK("comparator mux", i != 0, comparator_mux_allow)
        end
        // converter gated while enabled: sticky fault, cleared by writing one
        axw(sysctl_pkg::ADDR_GATE, 8'h01);
        i_part.set_periph(0, 0, 1);
        @(posedge clk);
        axr(sysctl_pkg::ADDR_STATUS);
        `CHK("fault set", 8'h09, rd)
        i_part.set_periph(0, 0, 0);
        axw(sysctl_pkg::ADDR_STATUS, 8'h08);
        axr(sysctl_pkg::ADDR_STATUS);
        `CHK("fault cleared", 8'h00, rd)
        axw(8'h70, 8'h00);
        `CHK("unmapped write", sysctl_pkg::RESP_SLVERR, rsp)
        i_part.set_periph(1, 0, 0);
        axw(sysctl_pkg::ADDR_GATE, 8'h40);
        `CHK("timer2 async runs", 1'b1, timer2_clk_en)
        axw(sysctl_pkg::ADDR_GATE, 8'h20);
        t0 = timer0_count;
        repeat (5) @(posedge clk);
        `CHK("timer0 frozen", t0, timer0_count)
        axw(sysctl_pkg::ADDR_GATE, 8'h00);
        repeat (5) @(posedge clk);
        `CHK("timer0 resumed", t0 + 16'h0005, timer0_count)
        // bandgap demand from comparator and converter, detector off
        for (int k = 0; k < 4; k++) begin
            i_part.set_periph(0, k[0], k[1]);
            repeat (2) @(posedge clk);
            `CHK("bandgap", k != 0, bandgap_on)
        end
        i_part.set_periph(0, 0, 0);
        brownout_level_fuse <= 3'h3;
        repeat (4) @(posedge clk);
        `CHK("brownout on", 2'h3, {bandgap_on, brownout_enable})
        `CHK("trigger level", 3'h3, brownout_trigger_level)
        // pin ignored when disabled, watchdog ignored outside reset mode
        reset_pin_disable_fuse <= 1;
        i_part.set_src(0, 1);
        i_part.set_src(3, 1);
        @(posedge clk);
        i_part.set_src(3, 0);
        @(posedge clk);
        #1 `CHK("ignored sources", 2'h0, {io_port_reset, sys_reset_active})
        @(posedge clk);
        i_part.set_src(0, 0);
        reset_pin_disable_fuse <= 0;
        // each source in turn with a longer delay selection each time
        for (int k = 0; k < 4; k++) begin
            axw(sysctl_pkg::ADDR_GATE, 8'hEF);
            startup_time_fuse <= k[1:0];
            wdt_reset_mode_en <= 1;
            i_part.set_src(k, 1);
            @(posedge clk);
            if (k == 3) i_part.set_src(k, 0);
            @(posedge clk);
            #1 `CHK("reset asserted", 1'b1, sys_reset_active)
            if (k < 3) `CHK("ports reset", 1'b1, io_port_reset)
            if (k < 3) i_part.set_src(k, 0);
            wait_run();
            `CHK("stretch long enough", 1'b1, n >= (8 << k))
            `CHK("stretch bounded", 1'b1, n <= (8 << k) + 6)
            axr(sysctl_pkg::ADDR_GATE);
            `CHK("gate cleared", 8'h00, rd)
        end
        finish_test();
    end
endmodule

`default_nettype wire
